// File: inc/pin_evt_if.sv
// Sampled link pin events passed from the pin sampler to the main logic
`timescale 1ns/1ps
interface pin_evt_if;
	logic       sck_rise;
	logic       sck_fall;
	logic [3:0] tsel_lvl;

	modport src (
		output sck_rise,
		output sck_fall,
		output tsel_lvl
	);
	modport sink (
		input sck_rise,
		input sck_fall,
		input tsel_lvl
	);
endinterface

// File: inc/spi_wake_defs.svh
// Register offsets, field positions, reset values, widths and responses for the wake and activity block
`ifndef SPI_WAKE_DEFS_SVH
`define SPI_WAKE_DEFS_SVH

// Byte offsets on the register bus
`define OFS_WAKE_FLAGS    8'h28
`define OFS_WAKE_ENABLES  8'h2c
`define OFS_ACT_STATUS    8'h30
`define OFS_IRQ_STATUS    8'h34
`define OFS_IRQ_CLEAR     8'h38
`define OFS_IRQ_ENABLE    8'h3c

// Wake flag and enable field positions
`define WK_TX_THD         0
`define WK_TXQ_DRAINED    1
`define WK_RX_THD         2
`define WK_RX_FULL        3
`define WK_W              4

// Activity status field position
`define ACT_BUSY          0

// Interrupt status field positions
`define IRQ_ACT_START     0
`define IRQ_ACT_END       1
`define IRQ_WAKE_RISE     2
`define IRQ_W             3

// Reset values
`define WAKE_FLAGS_RST    4'h0
`define WAKE_EN_RST       4'h0
`define IRQ_EN_RST        3'h0
`define IRQ_STAT_RST      3'h0
// Transmit FIFO starts empty, so its drained condition is taken as already seen
`define COND_RST          4'h2

// FIFO geometry and link widths
`define FIFO_DEPTH        4'h8
`define CNT_W             4
`define TSEL_W            4
`define BITCNT_W          4

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// File: inc/spi_wake_pkg.sv
// Types shared by the wake and activity block
package spi_wake_pkg;

	typedef enum logic [2:0] {
		SEL_NONE  = 3'b000,
		SEL_FLAGS = 3'b001,
		SEL_EN    = 3'b010,
		SEL_STAT  = 3'b011,
		SEL_ISTAT = 3'b100,
		SEL_ICLR  = 3'b101,
		SEL_IEN   = 3'b110
	} reg_sel_t;

	typedef enum logic {
		ACT_IDLE = 1'b0,
		ACT_RUN  = 1'b1
	} act_state_t;

endpackage

// File: logic/pin_sampler.sv
// Two-stage synchronisers for the serial clock and target-select pins, edge finding for the serial clock only
`timescale 1ns/1ps
`include "spi_wake_defs.svh"
module pin_sampler (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                sck_pin,
	input  wire logic [`TSEL_W-1:0]  tsel_n_pin,
	pin_evt_if.src                   evt
);

	localparam int PW = `TSEL_W + 1;

	wire  [PW-1:0] pins;
	logic [PW-1:0] meta_q;
	logic [PW-1:0] sync_q;
	logic          sck_hist_q;

	assign pins = {tsel_n_pin, sck_pin};

	////////////////////////////////////////////////////////////////////////////////
	// The first stage feeds only the second stage
	genvar g;
	generate
		for (g = 0; g < PW; g++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_q[g] <= (g == 0) ? 1'b0 : 1'b1;
					sync_q[g] <= (g == 0) ? 1'b0 : 1'b1;
				end else begin
					meta_q[g] <= pins[g];
					sync_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			sck_hist_q <= 1'b0;
		end else begin
			sck_hist_q <= sync_q[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Target selects are active low on the pins, active high inside
	assign evt.sck_rise = sync_q[0] & ~sck_hist_q;
	assign evt.sck_fall = ~sync_q[0] & sck_hist_q;
	assign evt.tsel_lvl = ~sync_q[PW-1:1];

endmodule

// File: logic/spi_wake_top.sv
// Wake flags, wake enables, activity status and interrupt logic of a serial port, on AXI4-Lite
//
// Overview of operation
// RULE1: Flag bit 3 sets when receive FIFO fills
// RULE2: Flag bit 2 sets on receive threshold crossing
// RULE3: Flag bit 1 sets when transmit queue drains
// RULE4: Flag bit 0 sets on transmit threshold; W1C
// RULE5: Enable bit 3 gates receive-full wake event
// RULE6: Enable bit 2 gates receive-threshold wake event
// RULE7: Enable bits 1,0 gate transmit wake events
// RULE8: Busy bit 0 read-only, resets idle
// RULE9: Controller mode: busy sets at transaction start
// RULE10: Controller mode: busy clears after last character
// RULE11: Target mode: busy sets on target select
// RULE12: Target mode: busy clears on select release
// RULE13: Receive threshold holds above level, ends below
// RULE14: Transmit threshold raised below programmed level
// RULE15: Wake output is OR of enabled flags
// RULE16: Reserved bits read zero, ignore writes
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "spi_wake_defs.svh"
module spi_wake_top (
	input  wire logic                 REF_CLK,
	input  wire logic                 RST,
	// AXI4-Lite slave
	input  wire logic [7:0]           S_AXI_AWADDR,
	input  wire logic                 S_AXI_AWVALID,
	output logic                      S_AXI_AWREADY,
	input  wire logic [31:0]          S_AXI_WDATA,
	input  wire logic [3:0]           S_AXI_WSTRB,
	input  wire logic                 S_AXI_WVALID,
	output logic                      S_AXI_WREADY,
	output logic [1:0]                S_AXI_BRESP,
	output logic                      S_AXI_BVALID,
	input  wire logic                 S_AXI_BREADY,
	input  wire logic [7:0]           S_AXI_ARADDR,
	input  wire logic                 S_AXI_ARVALID,
	output logic                      S_AXI_ARREADY,
	output logic [31:0]               S_AXI_RDATA,
	output logic [1:0]                S_AXI_RRESP,
	output logic                      S_AXI_RVALID,
	input  wire logic                 S_AXI_RREADY,
	// Port side, same clock
	input  wire logic [`CNT_W-1:0]    RX_FIFO_CNT,
	input  wire logic [`CNT_W-1:0]    TX_FIFO_CNT,
	input  wire logic [`CNT_W-1:0]    RX_LVL,
	input  wire logic [`CNT_W-1:0]    TX_LVL,
	input  wire logic                 CTRL_MODE,
	input  wire logic                 TXN_START,
	input  wire logic                 LAST_CHAR,
	input  wire logic [`BITCNT_W-1:0] CHAR_LEN_M1,
	input  wire logic [`TSEL_W-1:0]   TSEL_CFG,
	// Link pins, asynchronous
	input  wire logic                 SCK,
	input  wire logic [`TSEL_W-1:0]   TSEL_N,
	// Outputs
	output logic                      WAKE_REQ,
	output logic                      BUSY,
	output logic                      IRQ
);

	////////////////////////////////////////////////////////////////////////////////
	// Register decode, used for both the write and the read channel
	function automatic spi_wake_pkg::reg_sel_t reg_decode(input logic [7:0] a);
		logic [7:0] w;
		w = {2'h0, a[7:2]};
		if (w == `OFS_WAKE_FLAGS >> 2)
			reg_decode = spi_wake_pkg::SEL_FLAGS;
		else if (w == `OFS_WAKE_ENABLES >> 2)
			reg_decode = spi_wake_pkg::SEL_EN;
		else if (w == `OFS_ACT_STATUS >> 2)
			reg_decode = spi_wake_pkg::SEL_STAT;
		else if (w == `OFS_IRQ_STATUS >> 2)
			reg_decode = spi_wake_pkg::SEL_ISTAT;
		else if (w == `OFS_IRQ_CLEAR >> 2)
			reg_decode = spi_wake_pkg::SEL_ICLR;
		else if (w == `OFS_IRQ_ENABLE >> 2)
			reg_decode = spi_wake_pkg::SEL_IEN;
		else
			reg_decode = spi_wake_pkg::SEL_NONE;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Link pins
	pin_evt_if evt ();

	pin_sampler u_pins (
		.clk        (REF_CLK),
		.rst        (RST),
		.sck_pin    (SCK),
		.tsel_n_pin (TSEL_N),
		.evt        (evt.src)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic                      awready_q;
	logic                      wready_q;
	logic                      aw_full_q;
	logic                      w_full_q;
	logic [7:0]                awaddr_q;
	logic [31:0]               wdata_q;
	logic                      wstrb0_q;
	logic                      bvalid_q;
	logic [1:0]                bresp_q;
	logic                      arready_q;
	logic                      rvalid_q;
	logic [31:0]               rdata_q;
	logic [1:0]                rresp_q;

	logic [`WK_W-1:0]          flags_q;
	logic [`WK_W-1:0]          en_q;
	logic [`WK_W-1:0]          cond_q;
	logic                      wake_q;
	logic [`IRQ_W-1:0]         istat_q;
	logic [`IRQ_W-1:0]         ien_q;
	logic                      irq_q;
	spi_wake_pkg::act_state_t  act_q;
	spi_wake_pkg::act_state_t  act_d;
	logic [`BITCNT_W-1:0]      bitcnt_q;

	////////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data may arrive in either order
	wire                       aw_fire;
	wire                       w_fire;
	wire                       wr_do;
	wire                       ar_fire;
	wire                       r_done;
	wire                       b_done;
	wire                       aw_full_d;
	wire                       w_full_d;
	spi_wake_pkg::reg_sel_t    wr_sel;
	spi_wake_pkg::reg_sel_t    rd_sel;
	wire                       wr_lane;

	assign aw_fire   = S_AXI_AWVALID & awready_q;
	assign w_fire    = S_AXI_WVALID & wready_q;
	assign wr_do     = aw_full_q & w_full_q & ~bvalid_q;
	assign b_done    = bvalid_q & S_AXI_BREADY;
	assign ar_fire   = S_AXI_ARVALID & arready_q;
	assign r_done    = rvalid_q & S_AXI_RREADY;
	assign aw_full_d = (aw_full_q | aw_fire) & ~wr_do;
	assign w_full_d  = (w_full_q | w_fire) & ~wr_do;
	assign wr_sel    = reg_decode(awaddr_q);
	assign rd_sel    = reg_decode(S_AXI_ARADDR);
	// Only the low byte holds fields; upper lanes reach reserved bits only
	assign wr_lane   = wr_do & wstrb0_q;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			awready_q <= ~aw_full_d;
			wready_q  <= ~w_full_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (aw_fire) begin
			awaddr_q <= S_AXI_AWADDR;
		end
		if (w_fire) begin
			wdata_q  <= S_AXI_WDATA;
			wstrb0_q <= S_AXI_WSTRB[0];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `RESP_OKAY;
		end else if (wr_do) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_sel == spi_wake_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (b_done) begin
			bvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wake conditions
	wire                       rx_full_c;
	wire                       txq_drained_c;
	wire                       tx_thd_c;
	wire                       rx_thd_c;
	wire [`WK_W-1:0]           cond_d;
	wire [`WK_W-1:0]           cond_rise;
	wire [`WK_W-1:0]           flag_clr;
	wire [`WK_W-1:0]           flags_d;

	assign rx_full_c     = (RX_FIFO_CNT == `FIFO_DEPTH); // see RULE1
	assign txq_drained_c = (TX_FIFO_CNT == {`CNT_W{1'b0}}); // see RULE3
	assign tx_thd_c      = (TX_FIFO_CNT < TX_LVL); // see RULE14
	// Hysteresis: equal to the level keeps the previous state
	assign rx_thd_c      = (RX_FIFO_CNT > RX_LVL) ? 1'b1 :
	                       (RX_FIFO_CNT < RX_LVL) ? 1'b0 : cond_q[`WK_RX_THD]; // see RULE13

	assign cond_d = {rx_full_c, rx_thd_c, txq_drained_c, tx_thd_c};
	// A flag records the moment a condition starts, not its level
	assign cond_rise = cond_d & ~cond_q; // see RULE1 see RULE2 see RULE3 see RULE4

	// Writing 1 clears, 0 leaves alone, bits above 3 are dropped
	assign flag_clr = (wr_lane && wr_sel == spi_wake_pkg::SEL_FLAGS) ? wdata_q[`WK_W-1:0] :
	                  {`WK_W{1'b0}}; // see RULE4 see RULE16
	// An event in the clearing cycle is kept: set wins over clear
	assign flags_d  = (flags_q & ~flag_clr) | cond_rise; // see RULE1 see RULE2 see RULE3 see RULE4

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			cond_q  <= `COND_RST;
			flags_q <= `WAKE_FLAGS_RST;
		end else begin
			cond_q  <= cond_d;
			flags_q <= flags_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wake enables and wake request
	wire                       wake_d;

	assign wake_d = |(flags_q & en_q); // see RULE5 see RULE6 see RULE7 see RULE15

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			en_q <= `WAKE_EN_RST;
		end else if (wr_lane && wr_sel == spi_wake_pkg::SEL_EN) begin
			en_q <= wdata_q[`WK_W-1:0]; // see RULE5 see RULE6 see RULE7 see RULE16
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= wake_d; // see RULE15
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Activity tracking
	wire                       tsel_on;
	wire                       char_end;
	wire                       last_done;
	wire [`BITCNT_W-1:0]       bitcnt_d;

	assign tsel_on   = |(evt.tsel_lvl & TSEL_CFG);
	// Characters are counted on the sampled rising serial clock edge
	assign char_end  = evt.sck_rise && (bitcnt_q == CHAR_LEN_M1);
	assign last_done = CTRL_MODE && char_end && LAST_CHAR; // see RULE10
	assign bitcnt_d  = (act_q != spi_wake_pkg::ACT_RUN || !CTRL_MODE) ? {`BITCNT_W{1'b0}} :
	                   !evt.sck_rise ? bitcnt_q :
	                   char_end ? {`BITCNT_W{1'b0}} : bitcnt_q + {{(`BITCNT_W-1){1'b0}}, 1'b1};

	always_comb begin
		act_d = act_q;
		case (act_q)
			spi_wake_pkg::ACT_IDLE: begin
				if (CTRL_MODE ? TXN_START : tsel_on) begin
					act_d = spi_wake_pkg::ACT_RUN; // see RULE9 see RULE11
				end
			end
			spi_wake_pkg::ACT_RUN: begin
				if (CTRL_MODE ? last_done : !tsel_on) begin
					act_d = spi_wake_pkg::ACT_IDLE; // see RULE10 see RULE12
				end
			end
			default: begin
				act_d = spi_wake_pkg::ACT_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			act_q    <= spi_wake_pkg::ACT_IDLE; // see RULE8
			bitcnt_q <= {`BITCNT_W{1'b0}};
		end else begin
			act_q    <= act_d;
			bitcnt_q <= bitcnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky status, write-only clear, enable
	wire [`IRQ_W-1:0]          irq_evt;
	wire [`IRQ_W-1:0]          irq_clr;
	wire [`IRQ_W-1:0]          istat_d;

	assign irq_evt = {wake_d & ~wake_q,
	                  act_q == spi_wake_pkg::ACT_RUN && act_d == spi_wake_pkg::ACT_IDLE,
	                  act_q == spi_wake_pkg::ACT_IDLE && act_d == spi_wake_pkg::ACT_RUN};
	assign irq_clr = (wr_lane && wr_sel == spi_wake_pkg::SEL_ICLR) ? wdata_q[`IRQ_W-1:0] :
	                 {`IRQ_W{1'b0}};
	assign istat_d = (istat_q & ~irq_clr) | irq_evt;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			istat_q <= `IRQ_STAT_RST;
			ien_q   <= `IRQ_EN_RST;
			irq_q   <= 1'b0;
		end else begin
			istat_q <= istat_d;
			irq_q   <= |(istat_d & ien_q);
			if (wr_lane && wr_sel == spi_wake_pkg::SEL_IEN) begin
				ien_q <= wdata_q[`IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel: one read at a time, answered the cycle after address is taken
	wire [31:0]                rd_word;

	assign rd_word = (rd_sel == spi_wake_pkg::SEL_FLAGS) ? {28'h0000000, flags_q} : // see RULE16
	                 (rd_sel == spi_wake_pkg::SEL_EN)    ? {28'h0000000, en_q} :
	                 (rd_sel == spi_wake_pkg::SEL_STAT)  ? {31'h0, act_q == spi_wake_pkg::ACT_RUN} :
	                 (rd_sel == spi_wake_pkg::SEL_ISTAT) ? {29'h0, istat_q} :
	                 (rd_sel == spi_wake_pkg::SEL_IEN)   ? {29'h0, ien_q} :
	                 32'h00000000; // see RULE8

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= `RESP_OKAY;
		end else if (ar_fire) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_word;
			rresp_q   <= (rd_sel == spi_wake_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (r_done || !rvalid_q) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops
	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY  = wready_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_BRESP   = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RDATA   = rdata_q;
	assign S_AXI_RRESP   = rresp_q;
	assign WAKE_REQ      = wake_q;
	assign BUSY          = act_q;
	assign IRQ           = irq_q;

endmodule

// File: verif/link_peer.sv
// Far-side serial peer model driving the serial clock and target-select pins
`timescale 1ns/1ps
module link_peer (
	input  wire logic       go,
	input  wire logic       sel_en,
	input  wire logic [3:0] nbits,
	output logic            sck,
	output logic [3:0]      tsel_n,
	output logic            act
);
	initial begin
		sck = 1'h0;
		tsel_n = 4'hf;
		act = 1'h0;
	end
	// Clock stands low between frames; select lines idle high as if pulled up
	always @(posedge go) begin
		act = 1'h1;
		#7;
		if (sel_en) begin
			tsel_n = 4'he;
		end
		#200;
		repeat (nbits) begin
			sck = 1'h1;
			#160;
			sck = 1'h0;
			#160;
		end
		#200;
		tsel_n = 4'hf;
		act = 1'h0;
	end
endmodule

// File: verif/spi_wake_top_properties.sv
// Port-level checks for the wake and activity block
`timescale 1ns/1ps
`include "spi_wake_defs.svh"
module spi_wake_checker (
	input wire logic       REF_CLK,
	input wire logic       RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic       S_AXI_AWVALID,
	input wire logic       S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic       S_AXI_WVALID,
	input wire logic       S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic       S_AXI_BVALID,
	input wire logic       S_AXI_ARVALID,
	input wire logic       S_AXI_ARREADY,
	input wire logic       S_AXI_RVALID,
	input wire logic [3:0] RX_FIFO_CNT,
	input wire logic [3:0] TX_FIFO_CNT,
	input wire logic [3:0] TX_LVL,
	input wire logic       CTRL_MODE,
	input wire logic       TXN_START,
	input wire logic [3:0] TSEL_CFG,
	input wire logic       SCK,
	input wire logic [3:0] TSEL_N,
	input wire logic       WAKE_REQ,
	input wire logic       BUSY
);
	logic [3:0] en_q;
	logic [3:0] cond_q;
	// Shadow enables lead the design by a cycle; the windows below allow for it
	wire en_wr = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && S_AXI_WSTRB[0]
		&& S_AXI_AWADDR == `OFS_WAKE_ENABLES;
	wire aw_map = S_AXI_AWADDR inside {8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};
	// Receive threshold has hysteresis, so it is left out of the rise tracking
	wire [3:0] cond = {RX_FIFO_CNT == `FIFO_DEPTH, 1'b0, TX_FIFO_CNT == 4'h0, TX_FIFO_CNT < TX_LVL};
	wire [3:0] rise = cond & ~cond_q;
	wire sel = |(~TSEL_N & TSEL_CFG);
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			en_q <= `WAKE_EN_RST;
			cond_q <= `COND_RST;
		end else begin
			if (en_wr) begin
				en_q <= S_AXI_WDATA[3:0];
			end
			cond_q <= cond;
		end
	end
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	sequence s_sel_on;  (!CTRL_MODE && sel)[*6]; endsequence
	sequence s_sel_off; (!CTRL_MODE && !sel)[*6]; endsequence
	sequence s_sck_quiet; (CTRL_MODE && !SCK)[*6] ##1 (BUSY && CTRL_MODE && !SCK); endsequence
	property p_wake_fire; |(rise & en_q) |-> ##[1:4] WAKE_REQ; endproperty
	property p_wake_off; (en_q == 4'h0)[*3] |-> !WAKE_REQ; endproperty
	property p_busy_start; CTRL_MODE && TXN_START && !BUSY |-> ##[1:2] BUSY; endproperty
	property p_busy_hold; s_sck_quiet |=> BUSY; endproperty
	property p_busy_sel; s_sel_on |-> BUSY; endproperty
	property p_busy_rel; s_sel_off |-> !BUSY; endproperty
	property p_slverr; S_AXI_AWVALID && S_AXI_AWREADY && !aw_map
		|-> ##[1:8] (S_AXI_BVALID && S_AXI_BRESP == `RESP_SLVERR); endproperty
	property p_rd_lat; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
	a_wake_fire: assert property (p_wake_fire) else $error("wake request missing");
	a_wake_off: assert property (p_wake_off) else $error("wake request without enable");
	a_busy_start: assert property (p_busy_start) else $error("busy not set at start");
	a_busy_hold: assert property (p_busy_hold) else $error("busy cleared early");
	a_busy_sel: assert property (p_busy_sel) else $error("busy not set on select");
	a_busy_rel: assert property (p_busy_rel) else $error("busy kept after release");
	a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
endmodule
bind spi_wake_top spi_wake_checker spi_wake_checker_inst (.REF_CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
	.S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
	.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .RX_FIFO_CNT, .TX_FIFO_CNT, .TX_LVL, .CTRL_MODE,
	.TXN_START, .TSEL_CFG, .SCK, .TSEL_N, .WAKE_REQ, .BUSY);

// File: verif/test_spi_wake_and_activity_status.sv
// Self-checking bench for the wake and activity block
`timescale 1ns/1ps
`include "spi_wake_defs.svh"
module test_spi_wakeup_and_activity_status;
	logic        REF_CLK = 1'h0;
	logic        RST = 1'h1;
	logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic [3:0]  S_AXI_WSTRB = 4'hf, RX_FIFO_CNT = 4'h0, TX_FIFO_CNT = 4'h4, RX_LVL = 4'h4, TX_LVL = 4'h2;
	logic [3:0]  CHAR_LEN_M1 = 4'h7, TSEL_CFG = 4'h1;
	logic        CTRL_MODE = 1'h1, TXN_START = 1'h0, LAST_CHAR = 1'h1, go = 1'h0, sel_en = 1'h0;
	wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	wire  [31:0] S_AXI_RDATA;
	wire         SCK, WAKE_REQ, BUSY, IRQ, peer_act;
	wire  [3:0]  TSEL_N;
	int          errors = 0, comparisons = 0, n, i;
	logic [33:0] exp_q[$];
	logic [31:0] rnd = 32'hff2b8070;
	localparam logic [7:0] flg = `OFS_WAKE_FLAGS, ena = `OFS_WAKE_ENABLES, sta = `OFS_ACT_STATUS;
	logic [7:0]  offs [6] = '{8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};

	always #20 REF_CLK = ~REF_CLK;
	spi_wake_top spi_wake_top_inst (.*);
	link_peer link_peer_inst (.go(go), .sel_en(sel_en), .nbits(CHAR_LEN_M1 + 4'h1), .sck(SCK),
		.tsel_n(TSEL_N), .act(peer_act));
	////////////////////////////////////////////////////////////////////////////////
	function logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_of_test;
		// An answer that never came leaves its note behind
		errors += exp_q.size();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task tick(input int k);
		repeat (k) @(posedge REF_CLK);
	endtask
	task stuck;
		errors++;
		end_of_test();
	endtask
	task automatic pin(input logic v, input logic e);
		check({33'h0, v}, {33'h0, e});
	endtask
	// One bus transfer; a write offers address and data together and holds each until taken
	task xfer(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
		logic aw, w, ar;
		aw = !we;
		w = !we;
		ar = we;
		exp_q.push_back(e);
		if (we) begin
			S_AXI_AWADDR <= a;
			S_AXI_WDATA <= d;
			S_AXI_AWVALID <= 1'h1;
			S_AXI_WVALID <= 1'h1;
			S_AXI_BREADY <= 1'h1;
		end else begin
			S_AXI_ARADDR <= a;
			S_AXI_ARVALID <= 1'h1;
			S_AXI_RREADY <= 1'h1;
		end
		for (n = 0; !(aw && w && ar); n++) begin
			@(posedge REF_CLK);
			if (!aw && S_AXI_AWREADY) begin aw = 1'h1; S_AXI_AWVALID <= 1'h0; end
			if (!w && S_AXI_WREADY) begin w = 1'h1; S_AXI_WVALID <= 1'h0; end
			if (!ar && S_AXI_ARREADY) begin ar = 1'h1; S_AXI_ARVALID <= 1'h0; end
			if (n > 40) stuck();
		end
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
			if (n > 40) stuck();
		end while (S_AXI_BVALID !== 1'h1 && S_AXI_RVALID !== 1'h1);
		S_AXI_BREADY <= 1'h0;
		S_AXI_RREADY <= 1'h0;
		@(posedge REF_CLK);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d, 34'h0);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h0, a, 32'h0, {`RESP_OKAY, d});
	endtask
	// One frame from the peer; busy is looked at mid-frame and after the frame
	task frame(input logic mid, input logic post);
		go <= 1'h1;
		tick(20);
		go <= 1'h0;
		pin(BUSY, mid);
		for (n = 0; peer_act; n++) begin
			tick(1);
			if (n > 200) stuck();
		end
		tick(8);
		pin(BUSY, post);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge REF_CLK) begin
		if ((S_AXI_BVALID && S_AXI_BREADY) || (S_AXI_RVALID && S_AXI_RREADY)) begin
			check(S_AXI_BVALID ? {S_AXI_BRESP, 32'h0} : {S_AXI_RRESP, S_AXI_RDATA}, exp_q.pop_front());
		end
	end
	initial begin
		tick(12);
		RST <= 1'h0;
		tick(3);
		foreach (offs[k]) rd(offs[k], 32'h0);
		xfer(1'h0, 8'h40, 32'h0, {`RESP_SLVERR, 32'h0});
		xfer(1'h1, 8'h44, 32'hf, {`RESP_SLVERR, 32'h0});
		wr(sta, 32'h1);
		rd(sta, 32'h0);
		rnd = lfsr(rnd);
		wr(ena, rnd);
		rd(ena, {28'h0, rnd[3:0]});
		wr(ena, 32'h0);
		// Low byte lane off: the write must not land
		S_AXI_WSTRB <= 4'he;
		wr(ena, 32'hf);
		S_AXI_WSTRB <= 4'hf;
		rd(ena, 32'h0);
		$display("Test registers done");
		RX_FIFO_CNT <= 4'h8;
		TX_FIFO_CNT <= 4'h1;
		tick(4);
		TX_FIFO_CNT <= 4'h0;
		tick(4);
		rd(flg, 32'hf);
		wr(flg, 32'h0);
		rd(flg, 32'hf);
		pin(WAKE_REQ, 1'h0);
		for (i = 0; i < 4; i++) begin
			wr(ena, 32'h1 << i);
			tick(3);
			pin(WAKE_REQ, 1'h1);
			wr(flg, 32'h1 << i);
			tick(3);
			pin(WAKE_REQ, 1'h0);
		end
		RX_FIFO_CNT <= 4'h4;
		tick(3);
		RX_FIFO_CNT <= 4'h5;
		tick(3);
		rd(flg, 32'h0);
		RX_FIFO_CNT <= 4'h3;
		tick(3);
		RX_FIFO_CNT <= 4'h8;
		tick(3);
		rd(flg, 32'hc);
		pin(WAKE_REQ, 1'h1);
		wr(flg, 32'hf);
		wr(8'h38, 32'h7);
		$display("Test wake flags done");
		TXN_START <= 1'h1;
		tick(1);
		TXN_START <= 1'h0;
		tick(2);
		rd(sta, 32'h1);
		// A character that is not the last must leave the port busy
		LAST_CHAR <= 1'h0;
		frame(1'h1, 1'h1);
		LAST_CHAR <= 1'h1;
		frame(1'h1, 1'h0);
		rd(8'h34, 32'h3);
		wr(8'h3c, 32'h1);
		tick(2);
		pin(IRQ, 1'h1);
		wr(8'h3c, 32'h0);
		tick(2);
		pin(IRQ, 1'h0);
		wr(8'h38, 32'h3);
		rd(8'h34, 32'h0);
		$display("Test controller activity done");
		CTRL_MODE <= 1'h0;
		sel_en <= 1'h1;
		for (i = 0; i < 2; i++) begin
			TSEL_CFG <= 4'h1 << i;
			tick(2);
			frame(i == 0, 1'h0);
		end
		$display("Test target activity done");
		end_of_test();
	end
endmodule
